/* File: pmrs_map.svh */
// constants for the power-mode and reset sequencer: timing counts,
// field positions and reset values. assumes a 40 mhz system clock.
`ifndef PMRS_MAP_SVH
`define PMRS_MAP_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define PMRS_CLK_MHZ          40
`define PMRS_SLEEP_RESUME_US  15
`define PMRS_HIB_RESUME_US    100
`define PMRS_POR_PULSE_NS     100
`define PMRS_CLK_NS           25
// longest times round down, least time rounds up
`define PMRS_SLEEP_RESUME_CYC (`PMRS_SLEEP_RESUME_US * `PMRS_CLK_MHZ)
`define PMRS_HIB_RESUME_CYC   ((`PMRS_HIB_RESUME_US * `PMRS_CLK_MHZ) - 1)
`define PMRS_POR_PULSE_CYC    ((`PMRS_POR_PULSE_NS + `PMRS_CLK_NS - 1) / `PMRS_CLK_NS)
`define PMRS_TIMER_PERIOD     4000
`define PMRS_WDOG_PERIOD      65536

// ----------------------------------------------------------------------
// template and reset status fields
// ----------------------------------------------------------------------
`define PMRS_TMPL_W           8
`define PMRS_TMPL_CPU         0
`define PMRS_TMPL_FLASH       1
`define PMRS_ACT_TMPL_RST     8'hff
`define PMRS_ALT_TMPL_RST     8'hfc
`define PMRS_RST_STAT_W       8
`define PMRS_STAT_POR         0
`define PMRS_STAT_LVR         1
`define PMRS_STAT_PIN         2
`define PMRS_STAT_WDOG        3
`define PMRS_STAT_SOFT        4
`define PMRS_STAT_DLV         5
`define PMRS_STAT_ALV         6
`define PMRS_STAT_AHV         7

`endif

/* File: pmrs_pkg.sv */
// types shared by the power-mode and reset sequencer files.
// assumes the map header is included where constants are needed.
package pmrs_pkg;

  typedef enum logic [1:0] {
    PMRS_ACTIVE,
    PMRS_ALT_ACTIVE,
    PMRS_SLEEP,
    PMRS_HIBERNATE
  } pmrs_mode_t;

  typedef enum logic [1:0] {
    PMRS_SW_2M,
    PMRS_SW_400K,
    PMRS_SW_100K,
    PMRS_SW_32K
  } pmrs_boost_freq_t;

  typedef enum {
    PMRS_RUN,
    PMRS_RESUME
  } pmrs_seq_t;

endpackage

/* File: pmrs_sync.sv */
// two-flop synchroniser for a bus of asynchronous levels.
// assumes the inputs are slow levels; pulses shorter than one
// clock may be missed.
`timescale 1ns/10ps
module pmrs_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  initial begin
    if (WIDTH < 1) $error("pmrs_sync: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } pmrs_sync_t;

  pmrs_sync_t st;
  pmrs_sync_t next_st;

  always_comb begin
    next_st        = st;
    next_st.stage1 = async_in;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stage2;

endmodule

/* File: pmrs_boost_ctrl.sv */
// boost converter control: switching clock select, mode and
// automatic thump pulses on both crystal edges.
// assumes the crystal clock level is already synchronised.
`timescale 1ns/10ps
`include "pmrs_map.svh"
module pmrs_boost_ctrl (
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  // configuration
  input  wire pmrs_pkg::pmrs_boost_freq_t freq_sel,
  input  wire logic                      standby_req,
  input  wire logic                      thump_en,
  input  wire logic                      hibernate,
  // analog side
  input  wire logic                      xtal_level,
  input  wire logic                      boosted_output_low,
  // outputs
  output logic                           osc_sel_xtal,
  output logic [1:0]                     osc_freq,
  output logic                           boost_standby,
  output logic                           thump_pulse
);

  typedef struct packed {
    logic       xtal_prev;
    logic       sel_xtal;
    logic [1:0] freq;
    logic       standby;
    logic       pulse;
  } pmrs_boost_t;

  pmrs_boost_t st;
  pmrs_boost_t next_st;

  always_comb begin
    next_st           = st;
    next_st.xtal_prev = xtal_level;
    next_st.freq      = freq_sel;
    next_st.sel_xtal  = (freq_sel == pmrs_pkg::PMRS_SW_32K);
    next_st.standby   = standby_req && !hibernate;
    next_st.pulse     = st.standby && thump_en && boosted_output_low &&
                        (xtal_level != st.xtal_prev);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign osc_sel_xtal  = st.sel_xtal;
  assign osc_freq      = st.freq;
  assign boost_standby = st.standby;
  assign thump_pulse   = st.pulse;

endmodule

/* File: pmrs_top.sv */
// global power-mode and reset sequencer: clock gating from templates,
// sleep and hibernate entry and wakeup, reset sources and status.
// assumes all control bits come from firmware registers outside and
// asynchronous event inputs pass through the local synchroniser.
`timescale 1ns/10ps
`include "pmrs_map.svh"
module pmrs_top #(
  parameter int TMPL_W        = `PMRS_TMPL_W,
  parameter int TIMER_PERIOD  = `PMRS_TIMER_PERIOD,
  parameter int WDOG_PERIOD   = `PMRS_WDOG_PERIOD
) (
  // clock and power-on reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // supply monitors (asynchronous)
  input  wire logic                    supply_ramping,
  input  wire logic                    digital_supply_stable,
  input  wire logic                    precise_low_voltage_reset,
  input  wire logic                    digital_low_volt,
  input  wire logic                    analog_low_volt,
  input  wire logic                    analog_high_volt,
  // external pins and events (asynchronous)
  input  wire logic                    external_reset_pin_n,
  input  wire logic                    pin_irq,
  input  wire logic                    periph_irq,
  input  wire logic                    xtal_level,
  input  wire logic                    boosted_output_low,
  // firmware control
  input  wire logic [TMPL_W-1:0]       active_template,
  input  wire logic [TMPL_W-1:0]       alt_template,
  input  wire logic                    mode_req,
  input  wire pmrs_pkg::pmrs_mode_t    mode_req_sel,
  input  wire logic [3:0]              wake_en,
  input  wire logic [1:0]              lv_irq_not_reset,
  input  wire logic                    software_reset,
  input  wire logic                    software_reset_disable,
  input  wire logic                    watchdog_enable_set,
  input  wire logic                    watchdog_kick,
  input  wire logic                    timer_en,
  input  wire pmrs_pkg::pmrs_boost_freq_t boost_freq_sel,
  input  wire logic                    boost_standby_req,
  input  wire logic                    boost_thump_en,
  // power mode and gating outputs
  output pmrs_pkg::pmrs_mode_t         power_mode,
  output logic [TMPL_W-1:0]            clk_enable,
  output logic                         resuming,
  output logic                         io_hold,
  // reset and status outputs
  output logic                         device_reset,
  output logic                         oscillator_enable,
  output logic [`PMRS_RST_STAT_W-1:0]  reset_status,
  output logic                         watchdog_enabled,
  output logic                         supply_irq,
  output logic                         timer_irq,
  // boost outputs
  output logic                         boost_sel_xtal,
  output logic [1:0]                   boost_freq,
  output logic                         boost_standby,
  output logic                         boost_thump
);

  // ----------------------------------------------------------------------
  // parameter checks and constants
  // ----------------------------------------------------------------------
  initial begin
    if (TMPL_W < 2) $error("pmrs_top: TMPL_W must be at least 2");
    if (TIMER_PERIOD < 2) $error("pmrs_top: TIMER_PERIOD too small");
    if (WDOG_PERIOD < 2) $error("pmrs_top: WDOG_PERIOD too small");
  end

  localparam logic [12:0] SLEEP_CYC = 13'(`PMRS_SLEEP_RESUME_CYC);
  localparam logic [12:0] HIB_CYC   = 13'(`PMRS_HIB_RESUME_CYC);
  localparam logic [12:0] POR_CYC   = 13'(`PMRS_POR_PULSE_CYC);

  // ----------------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------------
  logic [10:0] raw;
  logic [10:0] syn;

  assign raw = {supply_ramping, digital_supply_stable, precise_low_voltage_reset,
                digital_low_volt, analog_low_volt, analog_high_volt,
                external_reset_pin_n, pin_irq, periph_irq, xtal_level,
                boosted_output_low};

  pmrs_sync #(
    .WIDTH (11)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (raw),
    .sync_out (syn)
  );

  logic s_ramp;
  logic s_dstable;
  logic s_prec;
  logic s_dlv;
  logic s_alv;
  logic s_ahv;
  logic s_pin_n;
  logic s_pin_irq;
  logic s_periph;
  logic s_xtal;
  logic s_blow;

  assign {s_ramp, s_dstable, s_prec, s_dlv, s_alv, s_ahv, s_pin_n,
          s_pin_irq, s_periph, s_xtal, s_blow} = syn;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    pmrs_pkg::pmrs_mode_t        mode;
    pmrs_pkg::pmrs_seq_t         seq;
    logic [12:0]                 resume_cnt;
    logic                        cpu_force;
    logic [TMPL_W-1:0]           clk_en;
    logic                        hold;
    logic [12:0]                 por_cnt;
    logic                        por_done;
    logic                        in_reset;
    logic                        osc_en;
    logic [`PMRS_RST_STAT_W-1:0] status;
    logic                        wdog_en;
    logic [31:0]                 wdog_cnt;
    logic [31:0]                 tmr_cnt;
    logic                        tmr_irq;
    logic                        sup_irq;
  } pmrs_state_t;

  pmrs_state_t st;
  pmrs_state_t next_st;

  function automatic logic [12:0] pmrs_dec(input logic [12:0] v);
    pmrs_dec = (v == 13'h0) ? 13'h0 : v - 13'h1;
  endfunction

  logic wake;
  logic lv_trip;
  logic dlv_reset;
  logic alv_reset;
  logic wdog_fire;
  logic any_reset;

  always_comb begin
    next_st   = st;
    dlv_reset = s_dlv && !lv_irq_not_reset[0];
    alv_reset = s_alv && !lv_irq_not_reset[1];
    lv_trip   = !s_prec || dlv_reset || alv_reset;
    wdog_fire = st.wdog_en && (st.wdog_cnt >= 32'(WDOG_PERIOD - 1));
    any_reset = lv_trip || !s_pin_n || wdog_fire ||
                (software_reset && !software_reset_disable);
    if (st.mode == pmrs_pkg::PMRS_HIBERNATE) begin
      wake = s_pin_irq;
    end else begin
      wake = (wake_en[0] && s_periph) || (wake_en[1] && st.sup_irq) ||
             (wake_en[2] && st.tmr_irq) || (wake_en[3] && s_pin_irq);
    end

    if (!st.por_done) begin
      next_st.por_cnt = pmrs_dec(st.por_cnt);
      if (s_ramp) begin
        next_st.por_cnt = POR_CYC;
      end
      if (st.por_cnt == 13'h0 && !s_ramp && s_dstable) begin
        next_st.por_done = 1'b1;
      end
    end
    next_st.osc_en = st.por_done && !lv_trip;

    // set wins, cleared only at power-on
    if (s_dlv) next_st.status[`PMRS_STAT_DLV] = 1'b1;
    if (s_alv) next_st.status[`PMRS_STAT_ALV] = 1'b1;
    if (s_ahv) next_st.status[`PMRS_STAT_AHV] = 1'b1;
    next_st.sup_irq = (s_dlv && lv_irq_not_reset[0]) ||
                      (s_alv && lv_irq_not_reset[1]) || s_ahv;

    if (watchdog_enable_set) next_st.wdog_en = 1'b1;
    if (watchdog_kick || !st.wdog_en) begin
      next_st.wdog_cnt = 32'h0;
    end else begin
      next_st.wdog_cnt = st.wdog_cnt + 32'h1;
    end

    next_st.tmr_irq = 1'b0;
    if (!timer_en) begin
      next_st.tmr_cnt = 32'h0;
    end else if (st.tmr_cnt >= 32'(TIMER_PERIOD - 1)) begin
      next_st.tmr_cnt = 32'h0;
      next_st.tmr_irq = 1'b1;
    end else begin
      next_st.tmr_cnt = st.tmr_cnt + 32'h1;
    end

    if (!st.por_done || any_reset) begin
      next_st.in_reset   = 1'b1;
      next_st.mode       = pmrs_pkg::PMRS_ACTIVE;
      next_st.seq        = pmrs_pkg::PMRS_RUN;
      next_st.cpu_force  = 1'b0;
      next_st.hold       = 1'b0;
      next_st.clk_en     = '0;
      next_st.resume_cnt = 13'h0;
      next_st.wdog_cnt   = 32'h0;
      next_st.tmr_cnt    = 32'h0;
      if (st.por_done) begin
        if (lv_trip)  next_st.status[`PMRS_STAT_LVR]  = 1'b1;
        if (!s_pin_n) next_st.status[`PMRS_STAT_PIN]  = 1'b1;
        if (wdog_fire) next_st.status[`PMRS_STAT_WDOG] = 1'b1;
        if (software_reset && !software_reset_disable) begin
          next_st.status[`PMRS_STAT_SOFT] = 1'b1;
        end
      end
    end else begin
      next_st.in_reset = 1'b0;
      case (st.seq)
        pmrs_pkg::PMRS_RUN: begin
          if (wake && st.mode != pmrs_pkg::PMRS_ACTIVE) begin
            if (st.mode == pmrs_pkg::PMRS_SLEEP ||
                st.mode == pmrs_pkg::PMRS_HIBERNATE) begin
              next_st.resume_cnt = (st.mode == pmrs_pkg::PMRS_SLEEP) ? SLEEP_CYC : HIB_CYC;
              next_st.seq        = pmrs_pkg::PMRS_RESUME;
            end else begin
              next_st.mode      = pmrs_pkg::PMRS_ACTIVE;
              next_st.cpu_force = 1'b1;
            end
          end else if (wake) begin
            next_st.cpu_force = 1'b1;
          end else if (mode_req) begin
            next_st.mode = mode_req_sel;
          end
          if (active_template[`PMRS_TMPL_CPU]) next_st.cpu_force = 1'b0;
        end
        pmrs_pkg::PMRS_RESUME: begin
          next_st.resume_cnt = pmrs_dec(st.resume_cnt);
          if (st.resume_cnt <= 13'h1) begin
            next_st.mode      = pmrs_pkg::PMRS_ACTIVE;
            next_st.cpu_force = 1'b1;
            next_st.seq       = pmrs_pkg::PMRS_RUN;
          end
        end
        default: begin
          next_st.seq = pmrs_pkg::PMRS_RUN;
        end
      endcase

      case (next_st.mode)
        pmrs_pkg::PMRS_ACTIVE:     next_st.clk_en = active_template;
        pmrs_pkg::PMRS_ALT_ACTIVE: next_st.clk_en = alt_template;
        default:                   next_st.clk_en = '0;
      endcase
      if (next_st.cpu_force) next_st.clk_en[`PMRS_TMPL_CPU] = 1'b1;
      next_st.hold = (next_st.mode == pmrs_pkg::PMRS_HIBERNATE);
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st          <= '0;
      st.mode     <= pmrs_pkg::PMRS_ACTIVE;
      st.in_reset <= 1'b1;
      st.por_cnt  <= POR_CYC;
      st.status   <= `PMRS_RST_STAT_W'(1 << `PMRS_STAT_POR);
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // boost converter
  // ----------------------------------------------------------------------
  pmrs_boost_ctrl u_boost (
    .sys_clk            (sys_clk),
    .rst_n              (rst_n),
    .freq_sel           (boost_freq_sel),
    .standby_req        (boost_standby_req),
    .thump_en           (boost_thump_en),
    .hibernate          (st.mode == pmrs_pkg::PMRS_HIBERNATE),
    .xtal_level         (s_xtal),
    .boosted_output_low (s_blow),
    .osc_sel_xtal       (boost_sel_xtal),
    .osc_freq           (boost_freq),
    .boost_standby      (boost_standby),
    .thump_pulse        (boost_thump)
  );

  assign power_mode        = st.mode;
  assign clk_enable        = st.clk_en;
  assign resuming          = (st.seq == pmrs_pkg::PMRS_RESUME);
  assign io_hold           = st.hold;
  assign device_reset      = st.in_reset;
  assign oscillator_enable = st.osc_en;
  assign reset_status      = st.status;
  assign watchdog_enabled  = st.wdog_en;
  assign supply_irq        = st.sup_irq;
  assign timer_irq         = st.tmr_irq;

endmodule

/* File: pmrs_board_model.sv */
// board model: supplies, external reset source and 32 khz crystal.
// assumes the bench steers it through three plain control levels.
`timescale 1ns/10ps
module pmrs_board_model #(
  parameter int XTAL_HALF_NS = 15259
) (
  // steering from the bench
  input  wire logic power_good,
  input  wire logic hold_reset,
  input  wire logic boost_low,
  // board side levels
  output logic      supply_ramping,
  output logic      digital_supply_stable,
  output logic      precise_low_voltage_reset,
  output logic      external_reset_pin_n,
  output logic      xtal_level,
  output logic      boosted_output_low
);
  // supplies ramp until power is good; the precise monitor trips with them
  assign supply_ramping            = !power_good;
  assign digital_supply_stable     = power_good;
  assign precise_low_voltage_reset = power_good;
  assign external_reset_pin_n      = !hold_reset;
  assign boosted_output_low        = boost_low;
  // the crystal runs free, unrelated in phase to the system clock
  initial xtal_level = 1'b0;
  always #(XTAL_HALF_NS) xtal_level = ~xtal_level;
endmodule

/* File: pmrs_checker_properties.sv */
// concurrent checks on the sequencer top ports.
// assumes one clock domain; attached by the bind at the foot.
`timescale 1ns/10ps
`include "pmrs_map.svh"
module pmrs_checker #(
  parameter int TMPL_W = 8
) (
  // clock and reset
  input wire logic                       sys_clk,
  input wire logic                       rst_n,
  // inputs watched
  input wire logic                       external_reset_pin_n,
  input wire logic                       pin_irq,
  input wire logic [3:0]                 wake_en,
  input wire logic                       software_reset,
  input wire logic                       software_reset_disable,
  input wire logic                       watchdog_enable_set,
  input wire pmrs_pkg::pmrs_boost_freq_t boost_freq_sel,
  // outputs watched
  input wire pmrs_pkg::pmrs_mode_t       power_mode,
  input wire logic [TMPL_W-1:0]          clk_enable,
  input wire logic                       resuming,
  input wire logic                       device_reset,
  input wire logic [`PMRS_RST_STAT_W-1:0] reset_status,
  input wire logic                       watchdog_enabled,
  input wire logic                       boost_sel_xtal,
  input wire logic                       boost_thump
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_boot_active;
    $rose(rst_n) |-> power_mode == pmrs_pkg::PMRS_ACTIVE && device_reset;
  endproperty
  a_boot_active: assert property (p_boot_active)
    else $error("mode not active after power-on");
  property p_status_sticky;
    1'b1 |=> (reset_status & $past(reset_status)) == $past(reset_status);
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("reset status bit cleared");
  property p_wdog_sticky;
    watchdog_enabled |=> watchdog_enabled;
  endproperty
  a_wdog_sticky: assert property (p_wdog_sticky)
    else $error("watchdog enable dropped");
  property p_wdog_set;
    watchdog_enable_set |-> ##[1:3] watchdog_enabled;
  endproperty
  a_wdog_set: assert property (p_wdog_set)
    else $error("watchdog enable not taken");
  property p_pin_reset;
    !external_reset_pin_n [*5] |-> device_reset;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("pin held low without reset");
  property p_soft_reset;
    software_reset && !software_reset_disable |-> ##[1:4] device_reset;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("software reset not taken");
  property p_sleep_wake;
    power_mode == pmrs_pkg::PMRS_SLEEP && pin_irq && wake_en[3] && !device_reset && !resuming
      |-> ##[1:4] resuming;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("enabled wakeup ignored in sleep");
  property p_sleep_time;
    $rose(resuming) && power_mode == pmrs_pkg::PMRS_SLEEP
      |-> ##[1:600] power_mode == pmrs_pkg::PMRS_ACTIVE;
  endproperty
  a_sleep_time: assert property (p_sleep_time)
    else $error("sleep resume too slow");
  logic [11:0] hib_cnt;
  always_ff @(posedge sys_clk)
    hib_cnt <= (resuming && power_mode == pmrs_pkg::PMRS_HIBERNATE) ? hib_cnt + 12'h1 : 12'h0;
  property p_hib_time;
    resuming && power_mode == pmrs_pkg::PMRS_HIBERNATE |-> hib_cnt < 12'hf9f;
  endproperty
  a_hib_time: assert property (p_hib_time)
    else $error("hibernate resume too slow");
  property p_cpu_back;
    $fell(resuming) |-> power_mode == pmrs_pkg::PMRS_ACTIVE && clk_enable[0];
  endproperty
  a_cpu_back: assert property (p_cpu_back)
    else $error("processor clock off after wakeup");
  property p_xtal_sel;
    $stable(boost_freq_sel) && !device_reset
      |=> device_reset || boost_sel_xtal == ($past(boost_freq_sel) == pmrs_pkg::PMRS_SW_32K);
  endproperty
  a_xtal_sel: assert property (p_xtal_sel)
    else $error("boost clock source wrong");
  property p_thump_pulse;
    boost_thump |=> !boost_thump;
  endproperty
  a_thump_pulse: assert property (p_thump_pulse)
    else $error("thump pulse longer than a cycle");
endmodule

bind pmrs_top pmrs_checker #(.TMPL_W(TMPL_W)) i_pmrs_checker (.*);

/* File: test_pmrs_top.sv */
// self-checking bench for the power-mode and reset sequencer.
// assumes the board model and checker compile before this file.
`timescale 1ns/10ps
`include "pmrs_map.svh"
module test_pmrs_top;
  typedef struct packed {
    logic [7:0]                 tmpl;
    pmrs_pkg::pmrs_boost_freq_t freq;
    logic                       xtal;
  } pmrs_row_t;
  // ----------------------------------------------------------------
  // stimulus and results
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0, rst_n = 1'b0, power_good = 1'b0, hold_reset = 1'b0, boost_low = 1'b0;
  logic supply_ramping, digital_supply_stable, precise_low_voltage_reset;
  logic external_reset_pin_n, xtal_level, boosted_output_low;
  logic digital_low_volt = 1'b0, analog_low_volt = 1'b0, analog_high_volt = 1'b0;
  logic pin_irq = 1'b0, periph_irq = 1'b0, mode_req = 1'b0, timer_en = 1'b0;
  logic [7:0] active_template = 8'hff, alt_template = 8'hfc;
  pmrs_pkg::pmrs_mode_t mode_req_sel = pmrs_pkg::PMRS_ACTIVE;
  logic [3:0] wake_en = 4'h0;
  logic [1:0] lv_irq_not_reset = 2'h0;
  logic software_reset = 1'b0, software_reset_disable = 1'b0;
  logic watchdog_enable_set = 1'b0, watchdog_kick = 1'b0;
  pmrs_pkg::pmrs_boost_freq_t boost_freq_sel = pmrs_pkg::PMRS_SW_2M;
  logic boost_standby_req = 1'b0, boost_thump_en = 1'b0;
  pmrs_pkg::pmrs_mode_t power_mode;
  logic [7:0] clk_enable, reset_status;
  logic [1:0] boost_freq;
  logic resuming, io_hold, device_reset, oscillator_enable, watchdog_enabled;
  logic supply_irq, timer_irq, boost_sel_xtal, boost_standby, boost_thump;
  int n_mismatch = 0, tests_run = 0, cnt, cnt2, n_timer, n_thump, n_xtal;
  pmrs_row_t rows [4] = '{'{8'hff, pmrs_pkg::PMRS_SW_2M, 1'b0},
                          '{8'ha5, pmrs_pkg::PMRS_SW_400K, 1'b0},
                          '{8'h3d, pmrs_pkg::PMRS_SW_100K, 1'b0},
                          '{8'h81, pmrs_pkg::PMRS_SW_32K, 1'b1}};

  // short periods keep the watchdog and timer scenarios brief
  pmrs_top #(.TIMER_PERIOD(16), .WDOG_PERIOD(16)) i_pmrs_top (.*);
  pmrs_board_model i_pmrs_board_model (.*);

  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (timer_irq === 1'b1) n_timer++;
    if (boost_thump === 1'b1) n_thump++;
  end
  always @(xtal_level) n_xtal++;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_byte({7'h0, got}, {7'h0, exp});
  endtask
  task automatic check_mode(input pmrs_pkg::pmrs_mode_t got, input pmrs_pkg::pmrs_mode_t exp);
    check_byte({6'h0, got}, {6'h0, exp});
  endtask
  task automatic request_mode(input pmrs_pkg::pmrs_mode_t m);
    mode_req_sel = m;
    mode_req = 1'b1;
    step(1);
    mode_req = 1'b0;
    step(2);
  endtask
  task automatic wait_reset(input logic v, input int lim);
    cnt = 0;
    while (device_reset !== v && cnt < lim) begin
      step(1);
      cnt++;
    end
    check_bit(device_reset, v);
  endtask
  // cnt2 counts the cycles spent resuming
  task automatic wait_active(input int lim);
    cnt = 0;
    cnt2 = 0;
    while (power_mode !== pmrs_pkg::PMRS_ACTIVE && cnt < lim) begin
      step(1);
      cnt++;
      if (resuming === 1'b1) cnt2++;
    end
    check_mode(power_mode, pmrs_pkg::PMRS_ACTIVE);
  endtask
  task automatic final_report;
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #750000;
    n_mismatch++;
    final_report();
  end

  initial begin
    step(2);
    rst_n = 1'b1;
    check_byte(reset_status, 8'h01);
    check_mode(power_mode, pmrs_pkg::PMRS_ACTIVE);
    check_bit(watchdog_enabled, 1'b0);
    step(10);
    check_bit(device_reset, 1'b1);
    power_good = 1'b1;
    wait_reset(1'b0, 40);
    check_bit(oscillator_enable, 1'b1);
    foreach (rows[i]) begin
      active_template = rows[i].tmpl;
      boost_freq_sel = rows[i].freq;
      step(2);
      check_byte(clk_enable, rows[i].tmpl);
      check_bit(boost_sel_xtal, rows[i].xtal);
      check_byte({6'h0, boost_freq}, {6'h0, rows[i].freq});
    end
    request_mode(pmrs_pkg::PMRS_ALT_ACTIVE);
    check_mode(power_mode, pmrs_pkg::PMRS_ALT_ACTIVE);
    check_byte(clk_enable, 8'hfc);
    request_mode(pmrs_pkg::PMRS_ACTIVE);
    active_template = 8'hfe;
    wake_en = 4'h8;
    step(2);
    check_bit(clk_enable[0], 1'b0);
    request_mode(pmrs_pkg::PMRS_SLEEP);
    pin_irq = 1'b1;
    wait_active(700);
    pin_irq = 1'b0;
    check_bit(cnt2 <= 600, 1'b1);
    check_byte(clk_enable, 8'hff);
    active_template = 8'hff;
    wake_en = 4'h4;
    n_timer = 0;
    request_mode(pmrs_pkg::PMRS_SLEEP);
    timer_en = 1'b1;
    wait_active(800);
    timer_en = 1'b0;
    check_bit(n_timer > 0, 1'b1);
    wake_en = 4'hf;
    boost_standby_req = 1'b1;
    request_mode(pmrs_pkg::PMRS_HIBERNATE);
    periph_irq = 1'b1;
    step(20);
    check_mode(power_mode, pmrs_pkg::PMRS_HIBERNATE);
    check_bit(io_hold, 1'b1);
    check_bit(boost_standby, 1'b0);
    periph_irq = 1'b0;
    pin_irq = 1'b1;
    wait_active(4100);
    pin_irq = 1'b0;
    check_bit(cnt2 < 4000, 1'b1);
    check_byte(reset_status, 8'h01);
    boost_thump_en = 1'b1;
    boost_freq_sel = pmrs_pkg::PMRS_SW_32K;
    boost_low = 1'b1;
    // align to a crystal edge so no edge straddles the window ends
    @(xtal_level);
    step(8);
    check_bit(boost_standby, 1'b1);
    n_thump = 0;
    n_xtal = 0;
    step(2000);
    cnt = n_xtal;
    step(8);
    check_byte(8'(n_thump), 8'(cnt));
    boost_low = 1'b0;
    step(8);
    n_thump = 0;
    step(1300);
    check_byte(8'(n_thump), 8'h00);
    lv_irq_not_reset = 2'b01;
    digital_low_volt = 1'b1;
    step(6);
    check_bit(supply_irq, 1'b1);
    check_bit(device_reset, 1'b0);
    check_bit(reset_status[`PMRS_STAT_DLV], 1'b1);
    digital_low_volt = 1'b0;
    software_reset_disable = 1'b1;
    software_reset = 1'b1;
    step(6);
    check_bit(device_reset, 1'b0);
    software_reset_disable = 1'b0;
    wait_reset(1'b1, 8);
    software_reset = 1'b0;
    wait_reset(1'b0, 40);
    check_byte(reset_status & 8'h11, 8'h11);
    for (int s = 0; s < 2; s++) begin
      hold_reset = (s == 0);
      power_good = (s == 0);
      step(6);
      check_bit(device_reset, 1'b1);
      hold_reset = 1'b0;
      power_good = 1'b1;
      wait_reset(1'b0, 40);
      check_bit(reset_status[s == 0 ? `PMRS_STAT_PIN : `PMRS_STAT_LVR], 1'b1);
    end
    watchdog_enable_set = 1'b1;
    step(1);
    watchdog_enable_set = 1'b0;
    wait_reset(1'b1, 60);
    check_bit(watchdog_enabled, 1'b1);
    check_bit(reset_status[`PMRS_STAT_WDOG], 1'b1);
    watchdog_kick = 1'b1;
    wait_reset(1'b0, 40);
    final_report();
  end
endmodule
